/* File: inc/sibh_pkg.sv */
// Package of constants and types for the SMBus indexed block host
package sibh_pkg;
   localparam int unsigned CLK_HZ         = 125_000_000;
   localparam int unsigned SMB_HZ         = 400_000;
   // Quarter bit period in clk_in cycles, rounded down, so the bus runs slightly above SMB_HZ
   localparam int unsigned QTR_CYC_INT    = CLK_HZ / (SMB_HZ * 4);
   localparam logic [9:0]  QTR_CYC        = QTR_CYC_INT[9:0];
   localparam logic [6:0]  ADDR_STRAP0    = 7'h6b;
   localparam logic [6:0]  ADDR_STRAP1    = 7'h6d;
   localparam logic        DIR_WRITE      = 1'b0;
   localparam logic        DIR_READ       = 1'b1;
   localparam logic [7:0]  BYTE_COUNT_RST = 8'h08;
   localparam int unsigned BUF_DEPTH      = 32;
   localparam int unsigned BUF_AW         = 5;

   typedef enum logic [7:0] {
      SIBH_IDLE  = 8'h01,
      SIBH_START = 8'h02,
      SIBH_BYTE  = 8'h04,
      SIBH_ACK   = 8'h08,
      SIBH_RSTRT = 8'h10,
      SIBH_STOP  = 8'h20,
      SIBH_DONE  = 8'h40,
      SIBH_LOAD  = 8'h80
   } sibh_state_t;

   typedef enum logic [2:0] {
      SIBH_PH_ADDRW = 3'h0,
      SIBH_PH_INDEX = 3'h1,
      SIBH_PH_COUNT = 3'h2,
      SIBH_PH_WDATA = 3'h3,
      SIBH_PH_ADDRR = 3'h4,
      SIBH_PH_RCNT  = 3'h5,
      SIBH_PH_RDATA = 3'h6
   } sibh_phase_t;
endpackage

/* File: hdl/sibh_buf.sv */
// Small byte buffer with registered read data
`timescale 1ns/1ps
module sibh_buf
   import sibh_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              wr_en_in,
   input  wire logic [BUF_AW-1:0] wr_addr_in,
   input  wire logic [7:0]        wr_data_in,
   input  wire logic [BUF_AW-1:0] rd_addr_in,
   output logic      [7:0]        rd_data_out
);
   logic [7:0] mem [BUF_DEPTH];

   // No reset on storage; contents are written before use
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule

/* File: hdl/sibh_host.sv */
// SMBus host for indexed block writes and reads of a clock buffer
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Start condition opens every transaction
// [RULE2] Send address with write bit, expect ack
// [RULE3] Send start index, expect ack
// [RULE4] Block write sends byte count next
// [RULE5] Send count data bytes in order
// [RULE6] Device acks every written byte
// [RULE7] Stop after last written byte acked
// [RULE8] Read uses repeated start, no stop
// [RULE9] Address with read bit after restart
// [RULE10] Device returns count byte first
// [RULE11] Device returns data from index onward
// [RULE12] Host acks count and all but last
// [RULE13] Nack last byte then stop
// [RULE14] Device address from latched strap
// [RULE15] Read length follows count register, default eight
// [RULE16] Reference clock must run during transfers; host checks ref_clk_ok_in only when accepting a start
// [RULE17] Device index advances per byte
module sibh_host
   import sibh_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              reset_n_in,
   input  wire logic              start_in,
   input  wire logic              read_in,
   input  wire logic              strap_in,
   input  wire logic [7:0]        index_in,
   input  wire logic [7:0]        count_in,
   input  wire logic              wr_en_in,
   input  wire logic [BUF_AW-1:0] wr_addr_in,
   input  wire logic [7:0]        wr_data_in,
   input  wire logic [BUF_AW-1:0] rd_addr_in,
   input  wire logic              ref_clk_ok_in,
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   scl_oe_out,
   output logic                   sda_oe_out,
   output logic                   busy_out,
   output logic                   done_out,
   output logic                   nack_err_out,
   output logic [7:0]             rd_count_out,
   output logic                   rd_valid_out,
   output logic [BUF_AW-1:0]      rd_idx_out,
   output logic [7:0]             rd_data_out
);
   sibh_state_t       state, next_state;
   sibh_phase_t       phase, next_phase;
   logic [9:0]        tick, next_tick;
   logic [1:0]        qtr, next_qtr;
   logic [2:0]        bit_n, next_bit_n;
   logic [7:0]        shreg, next_shreg;
   logic [7:0]        nbytes, next_nbytes;
   logic [BUF_AW-1:0] ptr, next_ptr;
   logic              rdmode, next_rdmode;
   logic              scl_oe, next_scl_oe;
   logic              sda_oe, next_sda_oe;
   logic              done, next_done;
   logic              nerr, next_nerr;
   logic              busy, next_busy;
   logic [7:0]        rcnt, next_rcnt;
   logic              rvld, next_rvld;
   logic [BUF_AW-1:0] ridx, next_ridx;
   logic [7:0]        rdat, next_rdat;
   logic [6:0]        dev_addr, next_dev_addr;
   logic [1:0]        scl_s, sda_s;
   logic [7:0]        buf_q;

   // Two flops on pins before any logic
   always_ff @(posedge clk_in) begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
   end

   sibh_buf u_buf (
      .clk_in      (clk_in),
      .wr_en_in    (wr_en_in),
      .wr_addr_in  (wr_addr_in),
      .wr_data_in  (wr_data_in),
      .rd_addr_in  (state == SIBH_IDLE ? rd_addr_in : ptr),
      .rd_data_out (buf_q)
   );

   always_comb begin
      next_state    = state;
      next_phase    = phase;
      next_tick     = tick;
      next_qtr      = qtr;
      next_bit_n    = bit_n;
      next_shreg    = shreg;
      next_nbytes   = nbytes;
      next_ptr      = ptr;
      next_rdmode   = rdmode;
      next_scl_oe   = scl_oe;
      next_sda_oe   = sda_oe;
      next_done     = 1'b0;
      next_nerr     = nerr;
      next_busy     = busy;
      next_rcnt     = rcnt;
      next_rvld     = 1'b0;
      next_ridx     = ridx;
      next_rdat     = rdat;
      next_dev_addr = dev_addr;
      if (state == SIBH_IDLE) begin
         next_scl_oe = 1'b0;
         next_sda_oe = 1'b0;
         next_busy   = 1'b0;
         // [RULE16] Hold off without ref clock
         if (start_in && ref_clk_ok_in) begin
            // [RULE14] Address from strap level
            next_dev_addr = strap_in ? ADDR_STRAP1 : ADDR_STRAP0;
            next_rdmode   = read_in;
            next_nbytes   = count_in;
            next_ptr      = '0;
            next_nerr     = 1'b0;
            next_busy     = 1'b1;
            next_tick     = '0;
            next_qtr      = '0;
            next_phase    = SIBH_PH_ADDRW;
            next_state    = SIBH_START;
         end
      end else if (tick != QTR_CYC - 10'h001) begin
         next_tick = tick + 10'h001;
      end else if (!scl_oe && !scl_s[1]) begin
         // Target holds clock low; wait rather than run ahead
         next_tick = tick;
      end else begin
         next_tick = '0;
         next_qtr  = qtr + 2'h1;
         case (state)
            // [RULE1] Start: data falls while clock high
            SIBH_START, SIBH_RSTRT: begin
               case (qtr)
                  2'h0: next_sda_oe = 1'b0;
                  2'h1: next_scl_oe = 1'b0;
                  2'h2: next_sda_oe = 1'b1;
                  default: begin
                     next_scl_oe = 1'b1;
                     next_bit_n  = 3'h7;
                     next_shreg  = {dev_addr, (state == SIBH_RSTRT) ? DIR_READ : DIR_WRITE};
                     next_state  = SIBH_BYTE;
                  end
               endcase
            end
            SIBH_BYTE: begin
               case (qtr)
                  2'h0: begin
                     next_sda_oe = (phase == SIBH_PH_RCNT || phase == SIBH_PH_RDATA) ? 1'b0 : ~shreg[7];
                  end
                  2'h1: next_scl_oe = 1'b0;
                  2'h2: begin
                     if (phase == SIBH_PH_RCNT || phase == SIBH_PH_RDATA) begin
                        next_shreg = {shreg[6:0], sda_s[1]};
                     end
                  end
                  default: begin
                     next_scl_oe = 1'b1;
                     if (!(phase == SIBH_PH_RCNT || phase == SIBH_PH_RDATA)) begin
                        next_shreg = {shreg[6:0], 1'b0};
                     end
                     next_bit_n = bit_n - 3'h1;
                     if (bit_n == 3'h0) begin
                        next_state = SIBH_ACK;
                     end
                  end
               endcase
            end
            SIBH_ACK: begin
               case (qtr)
                  2'h0: begin
                     // [RULE12] Ack all read bytes except last
                     // [RULE13] Nack the final read byte
                     if (phase == SIBH_PH_RCNT) begin
                        next_sda_oe = (shreg != 8'h00);
                     end else if (phase == SIBH_PH_RDATA) begin
                        next_sda_oe = (nbytes != 8'h01);
                     end else begin
                        next_sda_oe = 1'b0;
                     end
                  end
                  2'h1: next_scl_oe = 1'b0;
                  2'h2: begin
                     // [RULE2] [RULE6] Device ack checked
                     if (!(phase == SIBH_PH_RCNT || phase == SIBH_PH_RDATA) && sda_s[1]) begin
                        next_nerr = 1'b1;
                     end
                  end
                  default: begin
                     next_scl_oe = 1'b1;
                     next_bit_n  = 3'h7;
                     next_state  = SIBH_BYTE;
                     if (nerr) begin
                        next_state = SIBH_STOP;
                     end else begin
                        case (phase)
                           SIBH_PH_ADDRW: begin
                              // [RULE3] Index follows address
                              next_shreg = index_in;
                              next_phase = SIBH_PH_INDEX;
                           end
                           SIBH_PH_INDEX: begin
                              if (rdmode) begin
                                 // [RULE8] Restart without stop
                                 next_phase = SIBH_PH_ADDRR;
                                 next_state = SIBH_RSTRT;
                              end else begin
                                 // [RULE4] Count follows index
                                 next_shreg = nbytes;
                                 next_phase = SIBH_PH_COUNT;
                              end
                           end
                           SIBH_PH_COUNT, SIBH_PH_WDATA: begin
                              // [RULE5] Data bytes in order
                              if (nbytes == 8'h00) begin
                                 next_state = SIBH_STOP;
                              end else begin
                                 next_state = SIBH_LOAD;
                                 next_phase = SIBH_PH_WDATA;
                              end
                           end
                           // [RULE9] Read address acked, count next
                           SIBH_PH_ADDRR: next_phase = SIBH_PH_RCNT;
                           SIBH_PH_RCNT: begin
                              // [RULE10] [RULE15] Device count sets length
                              next_rcnt   = shreg;
                              next_nbytes = shreg;
                              next_phase  = SIBH_PH_RDATA;
                              if (shreg == 8'h00) begin
                                 next_state = SIBH_STOP;
                              end
                           end
                           default: begin
                              // [RULE11] [RULE17] Bytes stream in index order
                              next_rvld   = 1'b1;
                              next_ridx   = ptr;
                              next_rdat   = shreg;
                              next_ptr    = ptr + 5'h01;
                              next_nbytes = nbytes - 8'h01;
                              if (nbytes == 8'h01) begin
                                 next_state = SIBH_STOP;
                              end
                           end
                        endcase
                     end
                  end
               endcase
            end
            SIBH_LOAD: begin
               // Buffer read has one cycle latency, ample here
               next_shreg  = buf_q;
               next_ptr    = ptr + 5'h01;
               next_nbytes = nbytes - 8'h01;
               next_qtr    = '0;
               next_state  = SIBH_BYTE;
            end
            // [RULE7] [RULE13] Stop: data rises while clock high
            SIBH_STOP: begin
               case (qtr)
                  2'h0: next_sda_oe = 1'b1;
                  2'h1: next_scl_oe = 1'b0;
                  2'h2: next_sda_oe = 1'b0;
                  default: next_state = SIBH_DONE;
               endcase
            end
            default: begin
               next_done  = 1'b1;
               next_state = SIBH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         state    <= SIBH_IDLE;
         phase    <= SIBH_PH_ADDRW;
         tick     <= '0;
         qtr      <= '0;
         bit_n    <= '0;
         shreg    <= '0;
         nbytes   <= BYTE_COUNT_RST;
         ptr      <= '0;
         rdmode   <= 1'b0;
         scl_oe   <= 1'b0;
         sda_oe   <= 1'b0;
         done     <= 1'b0;
         nerr     <= 1'b0;
         busy     <= 1'b0;
         rcnt     <= '0;
         rvld     <= 1'b0;
         ridx     <= '0;
         rdat     <= '0;
         dev_addr <= ADDR_STRAP0;
      end else begin
         state    <= next_state;
         phase    <= next_phase;
         tick     <= next_tick;
         qtr      <= next_qtr;
         bit_n    <= next_bit_n;
         shreg    <= next_shreg;
         nbytes   <= next_nbytes;
         ptr      <= next_ptr;
         rdmode   <= next_rdmode;
         scl_oe   <= next_scl_oe;
         sda_oe   <= next_sda_oe;
         done     <= next_done;
         nerr     <= next_nerr;
         busy     <= next_busy;
         rcnt     <= next_rcnt;
         rvld     <= next_rvld;
         ridx     <= next_ridx;
         rdat     <= next_rdat;
         dev_addr <= next_dev_addr;
      end
   end

   assign scl_oe_out   = scl_oe;
   assign sda_oe_out   = sda_oe;
   assign busy_out     = busy;
   assign done_out     = done;
   assign nack_err_out = nerr;
   assign rd_count_out = rcnt;
   assign rd_valid_out = rvld;
   assign rd_idx_out   = ridx;
   assign rd_data_out  = rdat;
endmodule

/* File: testbench/sibh_host_monitor.sv */
// Checker of host sequencing at the controller ports
`timescale 1ns/1ps
module sibh_host_monitor (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic start_in,
   input wire logic ref_clk_ok_in,
   input wire logic scl_oe_out,
   input wire logic sda_oe_out,
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic nack_err_out,
   input wire logic rd_valid_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   AST_START_BUSY: assert property (start_in && ref_clk_ok_in && !busy_out |=> busy_out && !nack_err_out)
      else $error("accepted start did not raise busy");
   AST_REFUSE: assert property (!busy_out && !ref_clk_ok_in |=> !busy_out)
      else $error("start taken without reference clock");
   AST_START_COND: assert property ($rose(busy_out) |-> ##[1:1000] ($rose(sda_oe_out) && !scl_oe_out))
      else $error("no start condition after busy");
   AST_STOP_DONE: assert property ($fell(sda_oe_out) && !scl_oe_out |-> ##[1:700] done_out)
      else $error("stop not followed by done");
   AST_DONE_END: assert property (done_out |=> !done_out && !busy_out && !scl_oe_out && !sda_oe_out)
      else $error("lines or busy held after done");
   AST_IDLE_REL: assert property (!busy_out |-> !scl_oe_out && !sda_oe_out)
      else $error("bus driven while idle");
   AST_SCL_LOW_MIN: assert property ($rose(scl_oe_out) |-> scl_oe_out [*8])
      else $error("clock low phase too short");
   AST_RD_PULSE: assert property (rd_valid_out |-> busy_out ##1 !rd_valid_out)
      else $error("read byte strobe malformed");
   AST_NACK_HOLD: assert property (nack_err_out && !(start_in && ref_clk_ok_in && !busy_out) |=> nack_err_out)
      else $error("nack flag dropped early");
   cover property (done_out && !nack_err_out);
   cover property (rd_valid_out);
   cover property ($rose(nack_err_out));
endmodule
bind sibh_host sibh_host_monitor mon (.clk_in, .reset_n_in, .start_in, .ref_clk_ok_in, .scl_oe_out,
   .sda_oe_out, .busy_out, .done_out, .nack_err_out, .rd_valid_out);

/* File: testbench/sibh_dev_model.sv */
// Behavioural bus target with a 32-byte register array
`timescale 1ns/1ps
module sibh_dev_model
   import sibh_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   input  wire logic strap_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_oe_out
);
   logic [7:0] regs [0:31];
   logic [6:0] my_addr;
   logic [7:0] idx;
   logic [7:0] b;
   logic       ok;
   logic       again;
   int         c;
   always @(posedge clk_in) if (!reset_n_in) my_addr <= strap_in ? ADDR_STRAP1 : ADDR_STRAP0;
   // Returns 1 on start, 2 on stop seen mid-byte
   task automatic rx(output logic [7:0] v, output int cond);
      cond = 0;
      for (int i = 7; i >= 0; i--) begin
         @(posedge scl_in);
         v[i] = sda_in;
         @(negedge scl_in or sda_in);
         if (scl_in) begin
            cond = sda_in ? 2 : 1;
            return;
         end
      end
   endtask
   task automatic ack_byte;
      sda_oe_out = 1'b1;
      @(posedge scl_in);
      @(negedge scl_in);
      sda_oe_out = 1'b0;
   endtask
   task automatic tx_byte(input logic [7:0] v, output logic acked);
      for (int i = 7; i >= 0; i--) begin
         sda_oe_out = ~v[i];
         @(posedge scl_in);
         @(negedge scl_in);
      end
      sda_oe_out = 1'b0;
      @(posedge scl_in);
      acked = ~sda_in;
      @(negedge scl_in);
   endtask
   initial begin
      sda_oe_out = 1'b0;
      idx = 8'h00;
      foreach (regs[i]) regs[i] = 8'h00;
      regs[7] = BYTE_COUNT_RST;
      forever begin
         @(negedge sda_in iff scl_in === 1'b1);
         again = 1'b1;
         while (again) begin
            again = 1'b0;
            rx(b, c);
            if (c == 0 && b[7:1] == my_addr) begin
               ack_byte();
               if (b[0] == DIR_WRITE) begin
                  rx(b, c);
                  if (c == 0) begin
                     idx = b;
                     ack_byte();
                     rx(b, c);
                     again = (c == 1);
                     if (c == 0) ack_byte();
                     while (c == 0) begin
                        rx(b, c);
                        if (c == 0) begin
                           regs[idx[4:0]] = b;
                           idx++;
                           ack_byte();
                        end
                     end
                  end
               end else begin
                  tx_byte({3'h0, regs[7][4:0]}, ok);
                  for (int k = 0; k < int'(regs[7][4:0]) && ok; k++) begin
                     tx_byte(regs[idx[4:0]], ok);
                     idx++;
                  end
               end
            end
         end
      end
   end
endmodule

/* File: testbench/sibh_host_tb_top.sv */
// Self-checking bench of the indexed block host
`timescale 1ns/1ps
module sibh_host_tb_top;
   import sibh_pkg::*;
   logic       clk_in = 1'b0, reset_n_in = 1'b0, start_in = 1'b0, read_in = 1'b0, strap_in = 1'b0;
   logic [7:0] index_in = 8'h00, count_in = 8'h00, wr_data_in = 8'h00;
   logic       wr_en_in = 1'b0, ref_clk_ok_in = 1'b1;
   logic [4:0] wr_addr_in = 5'h00;
   logic       scl_oe, sda_oe, dev_sda_oe, busy_out, done_out, nack_err_out, rd_valid_out;
   logic [7:0] rd_count_out, rd_data_out;
   logic [4:0] rd_idx_out;
   logic [7:0] got_q[$];
   int         fails = 0;
   int         cmp_count = 0;
   wire        scl = ~scl_oe;
   wire        sda = ~(sda_oe | dev_sda_oe);
   always #4 clk_in = ~clk_in;
   sibh_host dut (.clk_in, .reset_n_in, .start_in, .read_in, .strap_in, .index_in, .count_in, .wr_en_in,
      .wr_addr_in, .wr_data_in, .rd_addr_in(5'h00), .ref_clk_ok_in, .scl_in(scl), .sda_in(sda),
      .scl_oe_out(scl_oe), .sda_oe_out(sda_oe), .busy_out, .done_out, .nack_err_out, .rd_count_out,
      .rd_valid_out, .rd_idx_out, .rd_data_out);
   sibh_dev_model dev (.clk_in, .reset_n_in, .strap_in(1'b0), .scl_in(scl), .sda_in(sda), .sda_oe_out(dev_sda_oe));
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic run(input logic r, input logic [7:0] n, input logic [7:0] x);
      int w;
      @(posedge clk_in);
      read_in <= r;
      index_in <= n;
      count_in <= x;
      start_in <= 1'b1;
      @(posedge clk_in);
      start_in <= 1'b0;
      w = 0;
      got_q.delete();
      while (done_out !== 1'b1 && w < 20000) begin
         @(negedge clk_in);
         w++;
         if (rd_valid_out === 1'b1) got_q.push_back(rd_data_out);
      end
      chk("done seen", 8'h01, {7'h0, done_out});
      @(posedge clk_in);
   endtask
   task automatic t_refuse;
      @(posedge clk_in);
      ref_clk_ok_in <= 1'b0;
      start_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      start_in <= 1'b0;
      ref_clk_ok_in <= 1'b1;
      @(negedge clk_in);
      chk("busy", 8'h00, {7'h0, busy_out});
   endtask
   task automatic t_nack;
      @(posedge clk_in);
      strap_in <= 1'b1;
      run(DIR_WRITE, 8'h00, 8'h01);
      strap_in <= 1'b0;
      chk("nack_err", 8'h01, {7'h0, nack_err_out});
      chk("reg0", 8'h00, dev.regs[0]);
   endtask
   task automatic t_write;
      @(posedge clk_in);
      wr_en_in <= 1'b1;
      wr_data_in <= 8'ha5;
      @(posedge clk_in);
      wr_addr_in <= 5'h01;
      wr_data_in <= 8'h01;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
      run(DIR_WRITE, 8'h06, 8'h02);
      chk("nack_err", 8'h00, {7'h0, nack_err_out});
      chk("reg6", 8'ha5, dev.regs[6]);
      chk("reg7", 8'h01, dev.regs[7]);
   endtask
   task automatic t_read;
      run(DIR_READ, 8'h06, 8'h00);
      chk("nack_err", 8'h00, {7'h0, nack_err_out});
      chk("rd_count", 8'h01, rd_count_out);
      chk("bytes", 8'h01, 8'(got_q.size()));
      chk("byte0", 8'ha5, got_q[0]);
      chk("rd_idx", 8'h00, {3'h0, rd_idx_out});
      chk("dev idx", 8'h07, dev.idx);
   endtask
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_in);
      reset_n_in <= 1'b1;
      t_refuse();
      t_nack();
      t_write();
      t_read();
      final_report();
   end
   // Three transfers at 400 kHz need about 270 us
   initial begin
      #500_000;
      fails++;
      final_report();
   end
endmodule
